// ===== hw/thermistor_pkg.sv
package thermistor_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ          = 25_000_000;
	localparam int BIAS_WINDOW_MS  = 25;
	localparam int BIAS_PERIOD_MS  = 225;
	localparam int BIAS_WINDOW_CYC = (CLK_HZ / 1000) * BIAS_WINDOW_MS;
	localparam int BIAS_PERIOD_CYC = (CLK_HZ / 1000) * BIAS_PERIOD_MS;
	localparam int INT_PULSE_US    = 128;
	localparam int INT_PULSE_CYC   = (CLK_HZ / 1_000_000) * INT_PULSE_US;
	localparam int CNT_W           = 23;
	localparam int IPULSE_W        = 12;

	// ****************************************
	// data widths and field positions
	// ****************************************
	localparam int ADC_FULL_SCALE_MV = 1200;
	localparam int CODE_W            = 16;
	localparam int THR_W             = 8;
	localparam int CODE_MSB_POS      = 8;
	localparam int CUR_W             = 8;
	localparam int SCALE_W           = 3;
	localparam int VREG_W            = 8;
	localparam int SLOT_N            = 4;
	localparam int SLOT_SEL_W        = 2;

	// ****************************************
	// thermal profiles
	// ****************************************
	localparam logic [1:0] MODE_FULL    = 2'h0;
	localparam logic [1:0] MODE_HOTCOLD = 2'h1;

	// ****************************************
	// thresholds, 8-bit codes of a 1.2 V scale
	// ****************************************
	typedef struct packed {
		logic [THR_W-1:0] open_lim;
		logic [THR_W-1:0] cold;
		logic [THR_W-1:0] cool;
		logic [THR_W-1:0] warm;
		logic [THR_W-1:0] hot;
	} thr_s;

	// 0.9 V, 0.585 V, 0.514 V, 0.265 V, 0.185 V
	localparam thr_s THR_DEF = '{
		open_lim: 8'hC0,
		cold:     8'h7C,
		cool:     8'h6D,
		warm:     8'h38,
		hot:      8'h27
	};

	typedef enum logic [2:0] {
		REG_NORMAL,
		REG_COOL,
		REG_WARM,
		REG_COLD,
		REG_HOT,
		REG_OPEN
	} region_e;

	typedef struct packed {
		logic open_lim;
		logic cold;
		logic hot;
	} fault_s;

	localparam fault_s FAULT_NONE = '{open_lim: 1'b0, cold: 1'b0, hot: 1'b0};

	// higher voltage means colder pack
	function automatic region_e classify(input logic [THR_W-1:0] code, input thr_s thr);
		region_e r;
		r = REG_NORMAL;
		if (code > thr.open_lim) begin
			r = REG_OPEN;
		end else if (code > thr.cold) begin
			r = REG_COLD;
		end else if (code > thr.cool) begin
			r = REG_COOL;
		end else if (code < thr.hot) begin
			r = REG_HOT;
		end else if (code < thr.warm) begin
			r = REG_WARM;
		end
		return r;
	endfunction

	// fraction (8 - code) / 8, floor keeps it on whole current steps
	function automatic logic [CUR_W-1:0] scale_current(input logic [CUR_W-1:0] cur,
		input logic [SCALE_W-1:0] code);
		logic [11:0] prod;
		prod = 12'(cur) * (12'h008 - 12'(code));
		return prod[10:3];
	endfunction

endpackage

// ===== hw/int_pulse_gen.sv
`timescale 1ns/10ps
module int_pulse_gen (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic trig,
	output logic      pulse_n
);
	logic [thermistor_pkg::IPULSE_W-1:0] cnt_r;
	logic [thermistor_pkg::IPULSE_W-1:0] cnt_nxt;
	logic                                pulse_n_r;
	logic                                pulse_n_nxt;

	localparam logic [thermistor_pkg::IPULSE_W-1:0] LEN_C =
		thermistor_pkg::IPULSE_W'(thermistor_pkg::INT_PULSE_CYC);

	// a new event restarts the pulse so none is swallowed
	always_comb begin
		cnt_nxt = cnt_r;
		pulse_n_nxt = pulse_n_r;
		if (trig) begin
			cnt_nxt = LEN_C - 12'h001;
			pulse_n_nxt = 1'b0;
		end else if (cnt_r != 12'h000) begin
			cnt_nxt = cnt_r - 12'h001;
		end else begin
			pulse_n_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= 12'h000;
			pulse_n_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			pulse_n_r <= pulse_n_nxt;
		end
	end

	assign pulse_n = pulse_n_r;
endmodule

// ===== hw/battery_thermistor_monitor.sv
`timescale 1ns/10ps
// Summary of operation
// [R1] bias 25 ms window every 225 ms
// [R2] bias sequencing forced on with supply
// [R3] full, hot/cold-only or disabled profile
// [R4] hot or cold pauses charge and timer
// [R5] cool region scales current, rounded down
// [R6] warm region uses lowered regulation voltage
// [R7] fault pulses interrupt in every profile
// [R8] fault flags latch until host read
// [R9] sense reading valid with supply or battery
// [R10] interrupt on every threshold crossing
// [R11] host reloads all thresholds
// [R12] open limit disables charging
// [R13] codes refer to 1.2 V full scale
// [R14] default thresholds per pack table
// [R15] compare top eight bits of code
// [R16] aux input biased and sampled alike
// [R17] aux result lands in chosen slot
// [R18] open flag on rising edge, pause held
// [R19] region updates only per completed sample
module battery_thermistor_monitor #(
	parameter int WINDOW_CYC = thermistor_pkg::BIAS_WINDOW_CYC,
	parameter int PERIOD_CYC = thermistor_pkg::BIAS_PERIOD_CYC
) (
	input  wire logic                                     SYS_CLK,
	input  wire logic                                     NRST,
	input  wire logic                                     INPUT_SUPPLY,
	input  wire logic                                     BATT_PRESENT,
	input  wire logic                                     BATT_SENSE_EN,
	input  wire logic [1:0]                               THERM_MODE,
	input  wire logic                                     THR_WR,
	input  wire thermistor_pkg::thr_s                     THR_WDATA,
	input  wire logic [thermistor_pkg::CUR_W-1:0]         FAST_CHARGE_CURRENT,
	input  wire logic [thermistor_pkg::SCALE_W-1:0]       COOL_CURRENT_SCALE,
	input  wire logic [thermistor_pkg::VREG_W-1:0]        VBAT_REG_NORMAL,
	input  wire logic [thermistor_pkg::VREG_W-1:0]        COOL_WARM_CHARGE_CTRL,
	input  wire logic                                     AUX_SENSE_EN,
	input  wire logic [thermistor_pkg::SLOT_SEL_W-1:0]    AUX_SLOT_SEL,
	input  wire logic [thermistor_pkg::SLOT_SEL_W-1:0]    SLOT_READ_SEL,
	input  wire logic                                     FLAG_READ,
	input  wire logic                                     ADC_DONE,
	input  wire logic [thermistor_pkg::CODE_W-1:0]        ADC_CODE,
	output logic                                          THERMISTOR_BIAS_CURRENT,
	output logic                                          AUX_BIAS_CURRENT,
	output logic                                          ADC_START,
	output logic                                          ADC_CHAN,
	output thermistor_pkg::thr_s                          THRESHOLDS,
	output thermistor_pkg::region_e                       REGION,
	output logic                                          CHARGE_PAUSE,
	output logic                                          TIMER_HOLD,
	output logic [thermistor_pkg::CUR_W-1:0]              CHARGE_CURRENT,
	output logic [thermistor_pkg::VREG_W-1:0]             VBAT_REG,
	output thermistor_pkg::fault_s                        FAULT_FLAGS,
	output logic                                          INT_N,
	output logic [thermistor_pkg::CODE_W-1:0]             SENSE_CODE,
	output logic                                          SENSE_VALID,
	output logic [thermistor_pkg::CODE_W-1:0]             SLOT_DATA
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] s1_r;
	logic [1:0] s2_r;
	logic [1:0] s3_r;
	logic [1:0] pins_r;
	logic [1:0] pins_nxt;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pins_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pins_r[i];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			s1_r <= 2'h0;
			s2_r <= 2'h0;
			s3_r <= 2'h0;
			pins_r <= 2'h0;
		end else begin
			s1_r <= {BATT_PRESENT, INPUT_SUPPLY};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pins_r <= pins_nxt;
		end
	end

	logic supply_ok;
	logic batt_ok;
	logic seq_active;
	assign supply_ok = pins_r[0];
	assign batt_ok = pins_r[1];
	// the enable only matters on battery; with supply it cannot stop bias
	assign seq_active = supply_ok | (batt_ok & BATT_SENSE_EN); // see [R2]

	// ****************************************
	// bias and sample sequencer
	// ****************************************
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_MAIN,
		SEQ_AUX
	} seq_e;

	localparam logic [thermistor_pkg::CNT_W-1:0] WIN_C =
		thermistor_pkg::CNT_W'(WINDOW_CYC);
	localparam logic [thermistor_pkg::CNT_W-1:0] PER_C =
		thermistor_pkg::CNT_W'(PERIOD_CYC);
	// sample mid-window so the bias has settled on the pin
	localparam logic [thermistor_pkg::CNT_W-1:0] SMP_C =
		thermistor_pkg::CNT_W'(WINDOW_CYC / 2);

	seq_e                               seq_r;
	seq_e                               seq_nxt;
	logic [thermistor_pkg::CNT_W-1:0]   cnt_r;
	logic [thermistor_pkg::CNT_W-1:0]   cnt_nxt;
	logic                               bias_r;
	logic                               bias_nxt;
	logic                               aux_bias_r;
	logic                               aux_bias_nxt;
	logic                               start_r;
	logic                               start_nxt;
	logic                               chan_r;
	logic                               chan_nxt;
	logic                               main_done;
	logic                               aux_done;

	always_comb begin
		seq_nxt = seq_r;
		cnt_nxt = cnt_r;
		start_nxt = 1'b0;
		chan_nxt = chan_r;
		main_done = 1'b0;
		aux_done = 1'b0;
		if (!seq_active) begin
			cnt_nxt = '0;
		end else if (cnt_r >= PER_C - 23'h000001) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + 23'h000001;
		end
		bias_nxt = seq_active && (cnt_nxt < WIN_C); // see [R1]
		aux_bias_nxt = bias_nxt && AUX_SENSE_EN; // see [R16]
		case (seq_r)
			SEQ_IDLE: begin
				if (seq_active && cnt_r == SMP_C) begin
					seq_nxt = SEQ_MAIN;
					start_nxt = 1'b1;
					chan_nxt = 1'b0;
				end
			end
			SEQ_MAIN: begin
				if (ADC_DONE) begin
					main_done = 1'b1;
					if (AUX_SENSE_EN) begin
						seq_nxt = SEQ_AUX; // see [R16]
						start_nxt = 1'b1;
						chan_nxt = 1'b1;
					end else begin
						seq_nxt = SEQ_IDLE;
					end
				end
			end
			SEQ_AUX: begin
				if (ADC_DONE) begin
					aux_done = 1'b1;
					seq_nxt = SEQ_IDLE;
					chan_nxt = 1'b0;
				end
			end
			default: begin
				seq_nxt = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			seq_r <= SEQ_IDLE;
			cnt_r <= '0;
			bias_r <= 1'b0;
			aux_bias_r <= 1'b0;
			start_r <= 1'b0;
			chan_r <= 1'b0;
		end else begin
			seq_r <= seq_nxt;
			cnt_r <= cnt_nxt;
			bias_r <= bias_nxt;
			aux_bias_r <= aux_bias_nxt;
			start_r <= start_nxt;
			chan_r <= chan_nxt;
		end
	end

	// ****************************************
	// thresholds and region
	// ****************************************
	thermistor_pkg::thr_s    thr_r;
	thermistor_pkg::thr_s    thr_nxt;
	thermistor_pkg::region_e region_r;
	thermistor_pkg::region_e region_nxt;
	thermistor_pkg::fault_s  flags_r;
	thermistor_pkg::fault_s  flags_nxt;
	thermistor_pkg::fault_s  cond_new;
	thermistor_pkg::fault_s  cond_old;
	logic                    region_event;

	always_comb begin
		thr_nxt = THR_WR ? THR_WDATA : thr_r; // see [R11]
		region_nxt = region_r;
		if (main_done) begin
			// codes are 256ths of full scale on a 1.2 V range
			region_nxt = thermistor_pkg::classify(
				ADC_CODE[thermistor_pkg::CODE_W-1:thermistor_pkg::CODE_MSB_POS],
				thr_r); // see [R15] see [R13] see [R19]
		end
		region_event = main_done && (region_nxt != region_r); // see [R10]
		cond_new.open_lim = (region_nxt == thermistor_pkg::REG_OPEN);
		cond_new.cold = (region_nxt == thermistor_pkg::REG_COLD);
		cond_new.hot = (region_nxt == thermistor_pkg::REG_HOT);
		cond_old.open_lim = (region_r == thermistor_pkg::REG_OPEN);
		cond_old.cold = (region_r == thermistor_pkg::REG_COLD);
		cond_old.hot = (region_r == thermistor_pkg::REG_HOT);
		// read clears, but a rising condition in that cycle still sets
		flags_nxt = FLAG_READ ? thermistor_pkg::FAULT_NONE : flags_r; // see [R8]
		flags_nxt = flags_nxt | (cond_new & ~cond_old); // see [R7] see [R18]
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			thr_r <= thermistor_pkg::THR_DEF; // see [R14]
			region_r <= thermistor_pkg::REG_NORMAL;
			flags_r <= thermistor_pkg::FAULT_NONE;
		end else begin
			thr_r <= thr_nxt;
			region_r <= region_nxt;
			flags_r <= flags_nxt;
		end
	end

	// ****************************************
	// charge control
	// ****************************************
	logic                                 pause_r;
	logic                                 pause_nxt;
	logic                                 hold_r;
	logic                                 hold_nxt;
	logic [thermistor_pkg::CUR_W-1:0]     cur_r;
	logic [thermistor_pkg::CUR_W-1:0]     cur_nxt;
	logic [thermistor_pkg::VREG_W-1:0]    vreg_r;
	logic [thermistor_pkg::VREG_W-1:0]    vreg_nxt;
	logic                                 prof_on;
	logic                                 prof_full;
	logic                                 hot_cold;

	always_comb begin
		prof_full = (THERM_MODE == thermistor_pkg::MODE_FULL); // see [R3]
		prof_on = prof_full || (THERM_MODE == thermistor_pkg::MODE_HOTCOLD); // see [R3]
		hot_cold = (region_r == thermistor_pkg::REG_HOT) ||
			(region_r == thermistor_pkg::REG_COLD);
		hold_nxt = prof_on && hot_cold; // see [R4]
		// an open pin stops charging whatever the profile
		pause_nxt = hold_nxt || (region_r == thermistor_pkg::REG_OPEN); // see [R12] see [R18]
		cur_nxt = FAST_CHARGE_CURRENT;
		if (prof_full && region_r == thermistor_pkg::REG_COOL) begin
			cur_nxt = thermistor_pkg::scale_current(FAST_CHARGE_CURRENT,
				COOL_CURRENT_SCALE); // see [R5]
		end
		vreg_nxt = VBAT_REG_NORMAL;
		if (prof_full && region_r == thermistor_pkg::REG_WARM) begin
			vreg_nxt = COOL_WARM_CHARGE_CTRL; // see [R6]
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			pause_r <= 1'b0;
			hold_r <= 1'b0;
			cur_r <= '0;
			vreg_r <= '0;
		end else begin
			pause_r <= pause_nxt;
			hold_r <= hold_nxt;
			cur_r <= cur_nxt;
			vreg_r <= vreg_nxt;
		end
	end

	// ****************************************
	// readings and data slots
	// ****************************************
	logic [thermistor_pkg::CODE_W-1:0] sense_r;
	logic [thermistor_pkg::CODE_W-1:0] sense_nxt;
	logic                              got_r;
	logic                              got_nxt;
	logic                              valid_r;
	logic                              valid_nxt;
	logic [thermistor_pkg::CODE_W-1:0] slot_r [thermistor_pkg::SLOT_N];
	logic [thermistor_pkg::CODE_W-1:0] slot_nxt [thermistor_pkg::SLOT_N];
	logic [thermistor_pkg::CODE_W-1:0] sdata_r;
	logic [thermistor_pkg::CODE_W-1:0] sdata_nxt;

	always_comb begin
		sense_nxt = main_done ? ADC_CODE : sense_r;
		got_nxt = got_r | main_done;
		valid_nxt = got_nxt && (supply_ok || batt_ok); // see [R9]
		for (int i = 0; i < thermistor_pkg::SLOT_N; i++) begin
			slot_nxt[i] = slot_r[i];
		end
		if (aux_done) begin
			slot_nxt[AUX_SLOT_SEL] = ADC_CODE; // see [R17]
		end
		sdata_nxt = slot_r[SLOT_READ_SEL];
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			sense_r <= '0;
			got_r <= 1'b0;
			valid_r <= 1'b0;
			sdata_r <= '0;
			for (int i = 0; i < thermistor_pkg::SLOT_N; i++) begin
				slot_r[i] <= '0;
			end
		end else begin
			sense_r <= sense_nxt;
			got_r <= got_nxt;
			valid_r <= valid_nxt;
			sdata_r <= sdata_nxt;
			for (int i = 0; i < thermistor_pkg::SLOT_N; i++) begin
				slot_r[i] <= slot_nxt[i];
			end
		end
	end

	// ****************************************
	// interrupt pulse
	// ****************************************
	// fault entries are region changes too, so one trigger serves both
	int_pulse_gen u_int (
		.clk     (SYS_CLK),
		.rst_n   (NRST),
		.trig    (region_event),
		.pulse_n (INT_N)
	); // see [R7] see [R10]

	assign THERMISTOR_BIAS_CURRENT = bias_r;
	assign AUX_BIAS_CURRENT = aux_bias_r;
	assign ADC_START = start_r;
	assign ADC_CHAN = chan_r;
	assign THRESHOLDS = thr_r;
	assign REGION = region_r;
	assign CHARGE_PAUSE = pause_r;
	assign TIMER_HOLD = hold_r;
	assign CHARGE_CURRENT = cur_r;
	assign VBAT_REG = vreg_r;
	assign FAULT_FLAGS = flags_r;
	assign SENSE_CODE = sense_r;
	assign SENSE_VALID = valid_r;
	assign SLOT_DATA = sdata_r;
endmodule

// ===== testbench/battery_thermistor_monitor_asserts.sv
`timescale 1ns/10ps
module battery_thermistor_monitor_asserts #(
	parameter int WINDOW_CYC = 20
) (
	input wire logic                    SYS_CLK,
	input wire logic                    NRST,
	input wire logic                    THERMISTOR_BIAS_CURRENT,
	input wire logic                    AUX_BIAS_CURRENT,
	input wire logic                    ADC_START,
	input wire logic                    ADC_DONE,
	input wire logic                    FLAG_READ,
	input wire logic                    CHARGE_PAUSE,
	input wire logic                    TIMER_HOLD,
	input wire logic                    INT_N,
	input wire thermistor_pkg::region_e REGION,
	input wire thermistor_pkg::fault_s  FAULT_FLAGS
);
	int run_r;
	int run_nxt;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	always_comb begin
		run_nxt = THERMISTOR_BIAS_CURRENT ? run_r + 1 : 0;
	end
	always_ff @(posedge SYS_CLK) begin
		run_r <= NRST ? run_nxt : 0;
	end

	sequence s_open2;
		REGION == thermistor_pkg::REG_OPEN ##1 REGION == thermistor_pkg::REG_OPEN;
	endsequence
	property p_bias_len;
		run_r <= WINDOW_CYC;
	endproperty
	a_bias_len: assert property (p_bias_len) else $error("bias window too long");
	property p_aux_bias;
		AUX_BIAS_CURRENT |-> THERMISTOR_BIAS_CURRENT;
	endproperty
	a_aux_bias: assert property (p_aux_bias) else $error("aux bias outside window");
	property p_start_one;
		ADC_START |=> !ADC_START;
	endproperty
	a_start_one: assert property (p_start_one) else $error("start longer than one cycle");
	property p_hold_pause;
		TIMER_HOLD |-> CHARGE_PAUSE;
	endproperty
	a_hold_pause: assert property (p_hold_pause) else $error("timer held, charge running");
	property p_open_pause;
		s_open2 |-> CHARGE_PAUSE;
	endproperty
	a_open_pause: assert property (p_open_pause) else $error("open without pause");
	property p_region_hold;
		$changed(REGION) |-> $past(ADC_DONE) || $past(ADC_DONE, 2);
	endproperty
	a_region_hold: assert property (p_region_hold) else $error("region moved between samples");
	property p_int_change;
		$changed(REGION) |-> ##[0:2] !INT_N;
	endproperty
	a_int_change: assert property (p_int_change) else $error("no interrupt on crossing");
	property p_int_len;
		$fell(INT_N) |=> !INT_N [*8];
	endproperty
	a_int_len: assert property (p_int_len) else $error("interrupt pulse too short");
	property p_flag_clear;
		FLAG_READ && !ADC_DONE && !$past(ADC_DONE) |=> FAULT_FLAGS == thermistor_pkg::FAULT_NONE;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flags kept after read");
	property p_flag_sticky;
		!FLAG_READ |=> (3'(FAULT_FLAGS) & $past(3'(FAULT_FLAGS))) == $past(3'(FAULT_FLAGS));
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped unread");
endmodule

bind battery_thermistor_monitor battery_thermistor_monitor_asserts #(.WINDOW_CYC(WINDOW_CYC))
	u_asserts (.SYS_CLK, .NRST, .THERMISTOR_BIAS_CURRENT, .AUX_BIAS_CURRENT, .ADC_START,
	.ADC_DONE, .FLAG_READ, .CHARGE_PAUSE, .TIMER_HOLD, .INT_N, .REGION, .FAULT_FLAGS);

// ===== testbench/adc_model.sv
`timescale 1ns/10ps
module adc_model (
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic        chan,
	input  wire logic [15:0] main_code,
	input  wire logic [15:0] aux_code,
	input  wire logic [3:0]  lat,
	output logic             done,
	output logic [15:0]      code
);
	initial begin
		done = 1'b0;
		code = 16'h0000;
	end
	// code is inverted once done drops so a late read never sees stale data
	always @(posedge clk) begin
		if (start) begin
			repeat (lat) @(posedge clk);
			done <= 1'b1;
			code <= chan ? aux_code : main_code;
			@(posedge clk);
			done <= 1'b0;
			code <= ~code;
		end
	end
endmodule

// ===== testbench/battery_thermistor_monitor_tb_top.sv
`timescale 1ns/10ps
module battery_thermistor_monitor_tb_top;
	logic                    sys_clk = 1'b0;
	logic                    nrst = 1'b0;
	logic                    sup = 1'b0;
	logic                    batt = 1'b0;
	logic                    bsen = 1'b0;
	logic                    thr_wr = 1'b0;
	logic                    aux_en = 1'b0;
	logic                    frd = 1'b0;
	logic [1:0]              mode = 2'h3;
	logic [1:0]              asel = 2'h0;
	logic [2:0]              scl = 3'h7;
	logic [7:0]              cur = 8'h00;
	logic [7:0]              vnorm = 8'h00;
	logic [7:0]              cwc = 8'h00;
	logic [15:0]             mcode = 16'h5000;
	logic [15:0]             acode = 16'h0000;
	logic [3:0]              lat = 4'h0;
	logic [31:0]             seed = 32'h0000001E;
	thermistor_pkg::thr_s    wdata = thermistor_pkg::THR_DEF;
	thermistor_pkg::thr_s    tcur = thermistor_pkg::THR_DEF;
	thermistor_pkg::thr_s    thr;
	thermistor_pkg::region_e region;
	thermistor_pkg::region_e prev = thermistor_pkg::REG_NORMAL;
	thermistor_pkg::fault_s  flags;
	logic [2:0]              ef = 3'h0;
	logic                    done, bias, abias, start, chan, pause, hold, int_n, svalid;
	logic [15:0]             code, scode, sdata;
	logic [7:0]              ccur, vreg;
	int                      miscompares = 0;
	int                      samples_checked = 0;
	int                      cycles = 0;
	int                      n;

	always #20 sys_clk = ~sys_clk;

	battery_thermistor_monitor #(.WINDOW_CYC(20), .PERIOD_CYC(180)) dut (
		.SYS_CLK(sys_clk), .NRST(nrst), .INPUT_SUPPLY(sup), .BATT_PRESENT(batt),
		.BATT_SENSE_EN(bsen), .THERM_MODE(mode), .THR_WR(thr_wr), .THR_WDATA(wdata),
		.FAST_CHARGE_CURRENT(cur), .COOL_CURRENT_SCALE(scl), .VBAT_REG_NORMAL(vnorm),
		.COOL_WARM_CHARGE_CTRL(cwc), .AUX_SENSE_EN(aux_en), .AUX_SLOT_SEL(asel),
		.SLOT_READ_SEL(asel), .FLAG_READ(frd), .ADC_DONE(done), .ADC_CODE(code),
		.THERMISTOR_BIAS_CURRENT(bias), .AUX_BIAS_CURRENT(abias), .ADC_START(start),
		.ADC_CHAN(chan), .THRESHOLDS(thr), .REGION(region), .CHARGE_PAUSE(pause),
		.TIMER_HOLD(hold), .CHARGE_CURRENT(ccur), .VBAT_REG(vreg), .FAULT_FLAGS(flags),
		.INT_N(int_n), .SENSE_CODE(scode), .SENSE_VALID(svalid), .SLOT_DATA(sdata));

	adc_model adc (.clk(sys_clk), .start(start), .chan(chan), .main_code(mcode),
		.aux_code(acode), .lat(lat), .done(done), .code(code));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic thermistor_pkg::region_e exp_region(input logic [7:0] b,
		input thermistor_pkg::thr_s t);
		if (b > t.open_lim) return thermistor_pkg::REG_OPEN;
		if (b > t.cold) return thermistor_pkg::REG_COLD;
		if (b > t.cool) return thermistor_pkg::REG_COOL;
		if (b < t.hot) return thermistor_pkg::REG_HOT;
		if (b < t.warm) return thermistor_pkg::REG_WARM;
		return thermistor_pkg::REG_NORMAL;
	endfunction

	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wait_done(input logic aux);
		int k;
		k = 0;
		while (!(done === 1'b1 && chan === aux) && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
		repeat (3) @(negedge sys_clk);
	endtask

	task automatic sample(input logic [15:0] c);
		thermistor_pkg::region_e er;
		logic                    h;
		mcode = c;
		acode = 16'(rnd());
		lat = 4'(rnd());
		wait_done(1'b0);
		er = exp_region(c[15:8], tcur);
		h = mode < 2'h2 && (er == thermistor_pkg::REG_HOT || er == thermistor_pkg::REG_COLD);
		check("region", region, er);
		check("hold", hold, h);
		check("pause", pause, h || er == thermistor_pkg::REG_OPEN);
		check("current", ccur, (mode == 2'h0 && er == thermistor_pkg::REG_COOL) ?
			8'((int'(cur) * (8 - int'(scl))) / 8) : cur);
		check("vreg", vreg, (mode == 2'h0 && er == thermistor_pkg::REG_WARM) ? cwc : vnorm);
		if (er != prev) begin
			check("int", int_n, 1'b0);
			ef |= (er == thermistor_pkg::REG_OPEN) ? 3'h4 : (er == thermistor_pkg::REG_COLD) ?
				3'h2 : (er == thermistor_pkg::REG_HOT) ? 3'h1 : 3'h0;
		end
		prev = er;
		check("flags", flags, ef);
		check("code", scode, c);
		check("valid", svalid, 1'b1);
		if (aux_en) begin
			wait_done(1'b1);
			check("slot", sdata, acode);
		end
		if (rnd() & 32'h1) begin
			frd = 1'b1;
			@(negedge sys_clk);
			frd = 1'b0;
			ef = 3'h0;
		end
	endtask

	task automatic bias_count(input int exp);
		int na;
		na = 0;
		n = 0;
		repeat (180) begin
			@(negedge sys_clk);
			n += bias;
			na += abias;
		end
		check("bias cycles", n, exp);
		check("aux bias cycles", na, aux_en ? exp : 0);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [7:0] corner [12] = '{8'hC1, 8'hC0, 8'h7D, 8'h7C, 8'h6E, 8'h6D,
			8'h37, 8'h38, 8'h26, 8'h27, 8'hFF, 8'h00};
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		check("thresholds", thr, thermistor_pkg::THR_DEF);
		check("int idle", int_n, 1'b1);
		// profile disabled and battery sensing off: bias must still run
		sup = 1'b1;
		aux_en = 1'b1;
		repeat (200) @(negedge sys_clk);
		bias_count(20);
		$display("bias test done");
		cur = 8'(rnd());
		vnorm = 8'(rnd());
		cwc = 8'(rnd());
		for (int i = 0; i < 12; i++) begin
			mode = 2'(i);
			asel = 2'(i);
			aux_en = i[0];
			sample({corner[i], 8'(rnd())});
		end
		$display("corner test done");
		wdata = '{open_lim: 8'hE0, cold: 8'h90, cool: 8'h70, warm: 8'h40, hot: 8'h20};
		thr_wr = 1'b1;
		@(negedge sys_clk);
		thr_wr = 1'b0;
		@(negedge sys_clk);
		check("new thresholds", thr, wdata);
		tcur = wdata;
		for (int i = 0; i < 24; i++) begin
			mode = 2'(rnd());
			scl = 3'(rnd());
			cur = 8'(rnd());
			aux_en = 1'(rnd());
			asel = 2'(rnd());
			sample(16'(rnd()));
		end
		$display("random test done");
		batt = 1'b1;
		bsen = 1'b1;
		sup = 1'b0;
		sample(16'h5000);
		bsen = 1'b0;
		repeat (200) @(negedge sys_clk);
		bias_count(0);
		$display("battery test done");
		end_sim();
	end
endmodule
